/* hdl/relay_output_conditioner.v */
/*
  relay output conditioner for relays 2, 3 and 4, AHB-Lite register slave.
  assumes condition inputs and card-detect pins are asynchronous and
  a single 100 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "relay_cond_defs.vh"

module relay_output_conditioner #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [7:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // condition sources, index is the assignment code
  input wire [6:0] cond_src_i,
  // expansion card detect
  input wire relay3_card_i,
  input wire relay4_card_i,
  // relay contacts
  output reg [2:0] relay_o
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // safety assignments where delay, hold and polarity are locked
  function locked_sel;
    input [2:0] asg;
    begin
      locked_sel = (asg == `SEL_NO_FAULT) || (asg == `SEL_BRAKE) ||
                   (asg == `SEL_PRECHARGE) || (asg == `SEL_LINE_CONT);
    end
  endfunction

  // clamp a millisecond field to the 9999 ms limit
  function [13:0] clamp_ms;
    input [13:0] v;
    begin
      clamp_ms = (v > `TIME_MAX_MS) ? `TIME_MAX_MS : v;
    end
  endfunction

  // ----------------------------------------------------------------------
  // synchronisers for pins
  // ----------------------------------------------------------------------
  reg [6:0] cond_meta;
  reg [6:0] cond_sync;
  reg [1:0] card_meta;
  reg [1:0] card_sync;

  // first stage read only by second stage
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cond_meta <= 7'h00;
      cond_sync <= 7'h00;
      card_meta <= 2'h0;
      card_sync <= 2'h0;
    end else begin
      cond_meta <= cond_src_i;
      cond_sync <= cond_meta;
      card_meta <= {relay4_card_i, relay3_card_i};
      card_sync <= card_meta;
    end
  end

  // ----------------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------------
  reg [16:0] tick_cnt;
  reg tick;

  // one-cycle pulse shared by all channels
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[16:0] - 17'h00001) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers, index 0 is relay 2
  // ----------------------------------------------------------------------
  reg [2:0] sel [0:2];
  reg [13:0] on_delay [0:2];
  reg [13:0] hold_time [0:2];
  reg pol [0:2];

  // ahb address phase capture
  reg wr_pend;
  reg [7:0] wr_addr;
  wire addr_ok = hsel_i && hready_i && htrans_i[1];
  wire [2:0] present = {card_sync, 1'b1};

  reg [1:0] wi;
  reg [2:0] wsel;
  integer i;

  // write decode picks the target relay; locks are applied later to the effective values
  always @* begin
    wi = 2'd3;
    if (wr_addr == `REG_RELAY2_CFG) begin
      wi = 2'd0;
    end else if (wr_addr == `REG_RELAY3_CFG && present[1]) begin
      wi = 2'd1;
    end else if (wr_addr == `REG_RELAY4_CFG && present[2]) begin
      wi = 2'd2;
    end
    wsel = hwdata_i[`F_SEL_LSB+2:`F_SEL_LSB];
  end

  // storage; unknown codes fall back to unassigned
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      sel[0] <= `RELAY2_SEL_RESET; // brake by default
      sel[1] <= `RELAY34_SEL_RESET;
      sel[2] <= `RELAY34_SEL_RESET;
      for (i = 0; i < 3; i = i + 1) begin
        on_delay[i] <= 14'h0000;
        hold_time[i] <= 14'h0000;
        pol[i] <= 1'b0; // positive default
      end
    end else begin
      wr_pend <= addr_ok && hwrite_i;
      wr_addr <= haddr_i;
      if (wr_pend && wi != 2'd3) begin
        // code set on the addressed relay only
        sel[wi] <= (wsel > `SEL_LINE_CONT) ? `SEL_NONE : wsel;
        on_delay[wi] <= clamp_ms(hwdata_i[`F_DELAY_LSB+13:`F_DELAY_LSB]);
        hold_time[wi] <= clamp_ms(hwdata_i[`F_HOLD_LSB+13:`F_HOLD_LSB]);
        pol[wi] <= hwdata_i[`F_POL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // effective settings and channels
  // ----------------------------------------------------------------------
  reg [13:0] eff_delay [0:2];
  reg [13:0] eff_hold [0:2];
  reg [2:0] eff_pol;
  reg [2:0] chan_cond;
  integer k;

  // locks act on the effective values, stored fields are ignored
  always @* begin
    for (k = 0; k < 3; k = k + 1) begin
      eff_delay[k] = (locked_sel(sel[k]) || sel[k] == `SEL_OUT_CONT) ? 14'h0000 : on_delay[k];
      eff_hold[k] = locked_sel(sel[k]) ? 14'h0000 : hold_time[k];
      eff_pol[k] = locked_sel(sel[k]) ? 1'b0 : pol[k]; // negative rejected
      chan_cond[k] = (sel[k] == `SEL_NONE) ? 1'b0 : cond_sync[sel[k]];
    end
  end

  wire [2:0] contact;
  wire [2:0] logic_state;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : chan
      relay_channel u_chan (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(tick),
        .enable_i(present[g]),
        .cond_i(chan_cond[g]),
        .on_delay_i(eff_delay[g]),
        .hold_time_i(eff_hold[g]),
        .active_low_polarity_i(eff_pol[g]),
        .contact_o(contact[g]),
        .logic_o(logic_state[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read data and outputs
  // ----------------------------------------------------------------------
  reg [31:0] rd;
  reg [1:0] ri;

  // read decode shows effective, locked values
  always @* begin
    rd = 32'h00000000;
    ri = 2'd3;
    if (haddr_i == `REG_RELAY2_CFG) begin
      ri = 2'd0;
    end else if (haddr_i == `REG_RELAY3_CFG && present[1]) begin
      ri = 2'd1;
    end else if (haddr_i == `REG_RELAY4_CFG && present[2]) begin
      ri = 2'd2;
    end else if (haddr_i == `REG_STATUS) begin
      rd = {23'h000000, present[2:1], 1'b0, logic_state, contact[2:1] & present[2:1], contact[0]};
    end else if (haddr_i == `REG_CONDITION) begin
      rd = {25'h0000000, cond_sync};
    end
    if (ri != 2'd3) begin
      rd = {sel[ri], eff_pol[ri], eff_hold[ri], eff_delay[ri]};
    end
  end

  // zero-wait answer; unmapped reads return zero, response always okay
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      relay_o <= 3'h0;
    end else begin
      if (addr_ok && !hwrite_i) begin
        hrdata_o <= rd;
      end
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      relay_o <= contact;
    end
  end

endmodule
`default_nettype wire

/* hdl/relay_cond_defs.vh */
/*
  constants for the relay output conditioner: register offsets, field
  positions, reset values, assignment codes and timing counts.
  assumes inclusion by bare name from the design files.
*/
`ifndef RELAY_COND_DEFS_VH
`define RELAY_COND_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets, one aligned word per register
// ----------------------------------------------------------------------
`define REG_RELAY2_CFG 8'h00
`define REG_RELAY3_CFG 8'h04
`define REG_RELAY4_CFG 8'h08
`define REG_STATUS 8'h0C
`define REG_CONDITION 8'h10

// ----------------------------------------------------------------------
// configuration word fields
// ----------------------------------------------------------------------
`define F_DELAY_LSB 0
`define F_HOLD_LSB 14
`define F_POL_BIT 28
`define F_SEL_LSB 29

// ----------------------------------------------------------------------
// assignment codes, three bits
// ----------------------------------------------------------------------
`define SEL_NONE 3'h0
`define SEL_USER 3'h1
`define SEL_NO_FAULT 3'h2
`define SEL_BRAKE 3'h3
`define SEL_OUT_CONT 3'h4
`define SEL_PRECHARGE 3'h5
`define SEL_LINE_CONT 3'h6

// ----------------------------------------------------------------------
// limits, reset values and timing
// ----------------------------------------------------------------------
`define TIME_MAX_MS 14'h270F
`define RELAY2_SEL_RESET 3'h3
`define RELAY34_SEL_RESET 3'h0
`define TICK_PERIOD_NS 1000000
`define CLK_PERIOD_NS 10
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

/* hdl/relay_channel.v */
/*
  one conditioned relay channel: on-delay, hold time and polarity.
  assumes a one-cycle millisecond tick on the same clock and a
  synchronised condition input.
*/
`timescale 1ns/100ps
`default_nettype none
`include "relay_cond_defs.vh"

module relay_channel (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // timing and condition
  input wire tick_i,
  input wire enable_i,
  input wire cond_i,
  input wire [13:0] on_delay_i,
  input wire [13:0] hold_time_i,
  input wire active_low_polarity_i,
  // contact and state
  output reg contact_o,
  output reg logic_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg [13:0] count;

  // counter reloads whenever condition and filtered state agree
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= 14'h0000;
      logic_o <= 1'b0;
    end else if (!enable_i) begin
      count <= 14'h0000;
      logic_o <= 1'b0;
    end else if (cond_i == logic_o) begin
      count <= 14'h0000; // early revert cancels a running count
    end else if ((cond_i && count >= on_delay_i) || (!cond_i && count >= hold_time_i)) begin
      logic_o <= cond_i;
      count <= 14'h0000;
    end else if (tick_i) begin
      count <= count + 14'h0001;
    end
  end

  // polarity after filtering so timing follows the logical state
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      contact_o <= 1'b0;
    end else begin
      contact_o <= enable_i & (logic_o ^ active_low_polarity_i);
    end
  end

endmodule
`default_nettype wire

/* sim/contact_load.sv */
/* far-side load: coils of the contactors driven by the relay contacts.
   assumes contact levels arrive on the conditioner clock. */
`timescale 1ns/100ps
`default_nettype none
module contact_load (
  // clock
  input wire logic ref_clk_i,
  // contacts in, coil state out
  input wire logic [2:0] relay_i,
  output var logic [2:0] energised_o
);
  // one-cycle pickup lag; a real coil is slower, never faster
  always @(posedge ref_clk_i) begin
    energised_o <= relay_i;
  end
endmodule
`default_nettype wire

/* sim/relay_cond_chk.sv */
/* port checker for the relay conditioner.
   bound to its top module; sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module relay_cond_chk #(
  parameter TICK_CYCLES = 10
) (
  // clock, reset, bus
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // cards and contacts
  input wire logic relay3_card_i,
  input wire logic relay4_card_i,
  input wire logic [2:0] relay_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic cfg_rd;
  logic [2:0] code;
  assign code = hrdata_o[31:29];
  // marks the data phase of a config read, when hrdata_o holds it
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      cfg_rd <= 1'b0;
    else
      cfg_rd <= hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i < 8'h0C && haddr_i[1:0] == 2'h0;
  end
  property p_lock;
    cfg_rd && code inside {3'h2, 3'h3, 3'h5, 3'h6} |-> hrdata_o[28:0] == 29'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("locked field set");
  property p_occ; cfg_rd && code == 3'h4 |-> hrdata_o[13:0] == 14'h0; endproperty
  a_occ: assert property (p_occ) else $error("delay not forced");
  property p_clamp;
    cfg_rd |-> hrdata_o[13:0] <= 14'h270F && hrdata_o[27:14] <= 14'h270F;
  endproperty
  a_clamp: assert property (p_clamp) else $error("time over range");
  property p_code; cfg_rd |-> code != 3'h7; endproperty
  a_code: assert property (p_code) else $error("bad code");
  // card removal must drop the contact within a few cycles
  property p_card3; !relay3_card_i [*8] |-> !relay_o[1]; endproperty
  a_card3: assert property (p_card3) else $error("relay3 live");
  property p_card4; !relay4_card_i [*8] |-> !relay_o[2]; endproperty
  a_card4: assert property (p_card4) else $error("relay4 live");
  property p_rst; $rose(rst_b_i) |-> relay_o == 3'h0 && hrdata_o == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_ok; hreadyout_o && !hresp_o; endproperty
  a_ok: assert property (p_ok) else $error("bus not okay");
endmodule
bind relay_output_conditioner relay_cond_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.ref_clk_i, .rst_b_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
  .relay3_card_i, .relay4_card_i, .relay_o);
`default_nettype wire

/* sim/relay_output_conditioner_tb_top.sv */
/* self-checking bench: ahb-lite master, config model and timing checks.
   assumes a 1 ms tick of 10 cycles and a zero-wait slave. */
`timescale 1ns/100ps
`default_nettype none
module relay_output_conditioner_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [6:0] cond_src_i = 7'h00;
  logic relay3_card_i = 1'b0;
  logic relay4_card_i = 1'b0;
  wire [31:0] hrdata_o;
  wire hreadyout_o;
  wire hresp_o;
  wire [2:0] relay_o;
  wire [2:0] load_w;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h0000001C;
  logic [31:0] r;
  logic [31:0] w;
  always #5 ref_clk_i = ~ref_clk_i;
  relay_output_conditioner #(.TICK_CYCLES(10)) i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .cond_src_i(cond_src_i), .relay3_card_i(relay3_card_i),
    .relay4_card_i(relay4_card_i), .relay_o(relay_o));
  contact_load i_load (.ref_clk_i(ref_clk_i), .relay_i(relay_o), .energised_o(load_w));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // effective config as read back: clamped, then forced by assignment
  function logic [31:0] eff(input logic [31:0] v);
    int c, d, h;
    logic p;
    c = v[31:29] == 3'h7 ? 0 : v[31:29];
    d = v[13:0] > 9999 ? 9999 : v[13:0];
    h = v[27:14] > 9999 ? 9999 : v[27:14];
    p = v[28];
    if (c >= 2)
      d = 0;
    if (c >= 2 && c != 4) begin
      h = 0;
      p = 1'b0;
    end
    return {c[2:0], p, h[13:0], d[13:0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // single word transfer; holds each phase until hready is seen high
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  // coil level of relay i after n cycles
  task automatic at(input int n, input int i, input logic e);
    cyc(n);
    chk(load_w[i], e);
  endtask
  task test_done;
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    test_done;
  end
  initial begin
    cyc(10);
    rst_b_i <= 1'b1;
    cyc(1);
    xfer(8'h00, 1'b0, 32'h0);
    chk(r, 32'h60000000);
    xfer(8'h04, 1'b1, 32'h20000005);
    xfer(8'h04, 1'b0, 32'h0);
    chk(r, 32'h0);
    xfer(8'h14, 1'b0, 32'h0);
    chk(r, 32'h0);
    relay3_card_i <= 1'b1;
    relay4_card_i <= 1'b1;
    cyc(4);
    xfer(8'h04, 1'b0, 32'h0);
    chk(r, 32'h0);
    // every code on every relay, random times and polarity
    for (int k = 0; k < 24; k++) begin
      w = rnd();
      w[31:29] = 3'(k / 3);
      xfer(8'(4 * (k % 3)), 1'b1, w);
      xfer(8'(4 * (k % 3)), 1'b0, 32'h0);
      chk(r, eff(w));
    end
    xfer(8'h00, 1'b1, {3'h1, 1'b0, 14'd2, 14'd3});
    cond_src_i <= 7'h02;
    at(20, 0, 1'b0);
    at(20, 0, 1'b1);
    cond_src_i <= 7'h00;
    cyc(5);
    cond_src_i <= 7'h02;
    repeat (30) at(1, 0, 1'b1);
    cond_src_i <= 7'h00;
    at(12, 0, 1'b1);
    at(18, 0, 1'b0);
    xfer(8'h00, 1'b1, {3'h1, 1'b1, 28'h0});
    at(10, 0, 1'b1);
    cond_src_i <= 7'h02;
    at(10, 0, 1'b0);
    xfer(8'h00, 1'b1, {3'h3, 1'b1, 14'd50, 14'd50});
    cond_src_i <= 7'h08;
    at(10, 0, 1'b1);
    cond_src_i <= 7'h00;
    at(10, 0, 1'b0);
    xfer(8'h08, 1'b1, 32'h0);
    xfer(8'h04, 1'b1, {3'h1, 29'h0});
    cond_src_i <= 7'h02;
    at(10, 1, 1'b1);
    // status: both cards, relay 3 on, relay 2 brake idle, relay 4 unassigned
    xfer(8'h0C, 1'b0, 32'h0);
    chk(r, 32'h00000192);
    xfer(8'h10, 1'b0, 32'h0);
    chk(r, 32'h00000002);
    relay3_card_i <= 1'b0;
    relay4_card_i <= 1'b0;
    at(12, 1, 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
